/* File: rtl/vbar_regs.sv */
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "vbar_consts.svh"
// Summary of operation
// - An 8-bit RW register holds destination slave address bits 11:4.
// - Address bits 3:0 sit in bits 7:4 of another register; 3:0 read 0.
// - An 8-bit RW length register, reset 0, gives the bytes to transmit.
// - A length above the frame maximum caps the frame at the maximum and sets frame_more.
// - A one-byte transmit buffer shows empty by a ready flag at one.
// - Each byte taken from the transmit buffer goes in the data field.
// - On rx, master address bits 3:0 land in bits 7:4 of a RO register.
// - On rx, master address bits 11:4 land in a separate RO register.
// - The rx captures update when the receive-start flag sets.
// - A broadcast rx error raises an error pulse and stores the address.
// - The control field reads in bits 3:0 of a RO register, 7:4 zero.
// - Writes to the rx address and control registers are ignored.

// ----------------------------------------
// tx byte fifo
// ----------------------------------------
module vbar_fifo #(
  parameter int WIDTH = `VBAR_FIFO_WIDTH,
  parameter int DEPTH = `VBAR_FIFO_DEPTH
) (
  input  wire logic             clk,       // system clock
  input  wire logic             reset,     // async, active high
  input  wire logic             in_valid,  // write side valid
  output logic                  in_ready,  // write side ready
  input  wire logic [WIDTH-1:0] in_data,   // write data
  output logic                  out_valid, // read side valid
  input  wire logic             out_ready, // read side ready
  output logic [WIDTH-1:0]      out_data   // read data
);
  import vbar_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } vbar_fifo_st_t;

  vbar_fifo_st_t st_q;
  vbar_fifo_st_t st_d;
  logic          push;
  logic          pop;

  assign in_ready  = st_q.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_q.cnt != '0;
  assign out_data  = st_q.mem[st_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wp] = in_data;
      st_d.wp           = st_q.wp + AW'(1);
    end
    if (pop) begin
      st_d.rp = st_q.rp + AW'(1);
    end
    case ({push, pop})
      2'b10:   st_d.cnt = st_q.cnt + (AW+1)'(1);
      2'b01:   st_d.cnt = st_q.cnt - (AW+1)'(1);
      default: st_d.cnt = st_q.cnt;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  fifo_no_overrun_a: assert property (st_q.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");

  fifo_empty_a: assert property (!out_valid |-> st_q.wp == st_q.rp)
    else $error("fifo pointers apart while empty");
endmodule // vbar_fifo

// ----------------------------------------
// register bank top
// ----------------------------------------
module vbar_regs (
  input  wire logic                   clk,          // 200 MHz clock
  input  wire logic                   reset,        // async, active high
  input  wire vbar_pkg::vbar_wb_req_t wb_req,       // wishbone request
  output vbar_pkg::vbar_wb_rsp_t      wb_rsp,       // wishbone answer
  output logic [11:0]                 dest_addr,    // destination slave
  output logic                        tx_buffer_empty_flag, // buf empty
  input  wire logic                   frame_start,  // new tx frame pulse
  input  wire logic [7:0]             frame_max,    // bytes per frame
  output logic [7:0]                  frame_bytes,  // bytes this frame
  output logic                        frame_more,   // more frames follow
  output logic                        tx_valid,     // tx byte valid
  input  wire logic                   tx_ready,     // tx byte taken
  output logic [7:0]                  tx_data,      // tx byte
  input  wire logic                   receive_start_flag, // rx start pulse
  input  wire vbar_pkg::vbar_rx_info_t rx_info,     // rx addr and ctrl
  input  wire logic                   ctrl_field_rx, // ctrl field pulse
  input  wire logic                   rx_buf_enabled, // rx buffer ready
  output logic                        rx_error      // rx error pulse
);
  import vbar_pkg::*;

  vbar_regs_st_t st_q;
  vbar_regs_st_t st_d;
  logic          req;
  logic          mapped;
  logic [2:0]    idx;
  logic          wr;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic          fifo_out_ready;
  logic [7:0]    fifo_out_data;
  logic          bcast_err;
  logic [31:0]   rd_word;

  assign req    = wb_req.cyc && wb_req.stb;
  assign idx    = wb_req.adr[`VBAR_ADR_IDX];
  assign mapped = wb_req.adr[`VBAR_ADR_UPPER] == '0;
  // write commits on the edge where ack is seen high
  assign wr     = req && wb_req.we && st_q.ack && mapped
                  && wb_req.sel[`VBAR_SEL_LANE0];

  // ----------------------------------------
  // transmit path
  // ----------------------------------------
  vbar_fifo #(
    .WIDTH(`VBAR_FIFO_WIDTH),
    .DEPTH(`VBAR_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (st_q.tx_full),
    .in_ready  (fifo_in_ready),
    .in_data   (st_q.tx_hold),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_out_ready = tx_ready && st_q.frame_left != '0;
  assign tx_valid       = fifo_out_valid && st_q.frame_left != '0;
  assign tx_data        = fifo_out_data;
  assign tx_buffer_empty_flag = !st_q.tx_full;
  assign dest_addr      = {st_q.dsa_hi, st_q.dsa_lo};
  assign frame_bytes    = st_q.frame_bytes;
  assign frame_more     = st_q.frame_more;
  assign rx_error       = st_q.rx_err;
  assign wb_rsp.ack     = st_q.ack;
  assign wb_rsp.dat     = st_q.rdata;
  assign bcast_err      = ctrl_field_rx && st_q.bcast_sel && !rx_buf_enabled;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd_word = `VBAR_ZERO_WORD;
    if (mapped) begin
      case (idx)
        `VBAR_IDX_DSA_HI: rd_word[`VBAR_BYTE] = st_q.dsa_hi;
        `VBAR_IDX_DSA_LO: rd_word[`VBAR_BYTE] =
                            {st_q.dsa_lo, `VBAR_ZERO_NIB};
        `VBAR_IDX_TX_LEN: rd_word[`VBAR_BYTE] = st_q.tx_len;
        `VBAR_IDX_TX_BUF: rd_word[`VBAR_BYTE] = st_q.tx_hold;
        `VBAR_IDX_MA_LO:  rd_word[`VBAR_BYTE] =
                            {st_q.ma_lo, `VBAR_ZERO_NIB};
        `VBAR_IDX_MA_HI:  rd_word[`VBAR_BYTE] = st_q.ma_hi;
        `VBAR_IDX_RX_CTL: rd_word[`VBAR_BYTE] =
                            {`VBAR_ZERO_NIB, st_q.rx_ctl};
        `VBAR_IDX_STATUS: begin
          rd_word[`VBAR_ST_TXE_BIT]  = !st_q.tx_full;
          rd_word[`VBAR_ST_BSEL_BIT] = st_q.bcast_sel;
        end
        default: rd_word = `VBAR_ZERO_WORD;
      endcase
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_d        = st_q;
    st_d.ack    = req && !st_q.ack;
    st_d.rdata  = (req && !st_q.ack) ? rd_word : `VBAR_ZERO_WORD;
    st_d.rx_err = bcast_err;

    // byte moves to the fifo, buffer reads empty again
    if (st_q.tx_full && fifo_in_ready) begin
      st_d.tx_full = 1'b0;
    end

    if (wr) begin
      case (idx)
        `VBAR_IDX_DSA_HI: st_d.dsa_hi = wb_req.dat[`VBAR_BYTE];
        `VBAR_IDX_DSA_LO: st_d.dsa_lo = wb_req.dat[`VBAR_NIB_HI];
        `VBAR_IDX_TX_LEN: st_d.tx_len = wb_req.dat[`VBAR_BYTE];
        `VBAR_IDX_TX_BUF: begin
          st_d.tx_hold = wb_req.dat[`VBAR_BYTE];
          st_d.tx_full = 1'b1;
        end
        `VBAR_IDX_STATUS: st_d.bcast_sel = wb_req.dat[`VBAR_ST_BSEL_BIT];
        // captured rx registers drop writes
        default: st_d.tx_full = st_d.tx_full;
      endcase
    end

    // frame byte accounting, length register left untouched
    if (frame_start) begin
      if (st_q.tx_len > frame_max) begin
        st_d.frame_left  = frame_max;
        st_d.frame_bytes = frame_max;
        st_d.frame_more  = 1'b1;
      end else begin
        st_d.frame_left  = st_q.tx_len;
        st_d.frame_bytes = st_q.tx_len;
        st_d.frame_more  = 1'b0;
      end
    end else if (fifo_out_valid && fifo_out_ready) begin
      st_d.frame_left = st_q.frame_left - `VBAR_ONE_BYTE;
    end

    if (receive_start_flag || bcast_err) begin
      st_d.ma_lo = rx_info.master_addr[`VBAR_ADDR_LO];
      st_d.ma_hi = rx_info.master_addr[`VBAR_ADDR_HI];
    end
    if (receive_start_flag) begin
      st_d.rx_ctl = rx_info.ctrl;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  dsa_hi_write_a: assert property (
    wr && idx == `VBAR_IDX_DSA_HI |=> st_q.dsa_hi == $past(wb_req.dat[7:0]))
    else $error("destination high byte not stored");

  dsa_lo_read_a: assert property (
    req && !st_q.ack && !wb_req.we && mapped && idx == `VBAR_IDX_DSA_LO
    |=> wb_rsp.ack && wb_rsp.dat[7:0] == {st_q.dsa_lo, 4'h0}
        && wb_rsp.dat[31:8] == '0)
    else $error("destination low register read wrong");

  frame_len_a: assert property (
    frame_start && st_q.tx_len <= frame_max
    |=> frame_bytes == $past(st_q.tx_len) && !frame_more)
    else $error("frame length not taken from length register");

  frame_split_a: assert property (
    frame_start && st_q.tx_len > frame_max
    |=> frame_more && frame_bytes == $past(frame_max))
    else $error("long message not split");

  len_stable_a: assert property (
    !(wr && idx == `VBAR_IDX_TX_LEN) |=> $stable(st_q.tx_len))
    else $error("length register changed by hardware");

  txbuf_write_a: assert property (
    wr && idx == `VBAR_IDX_TX_BUF |=> !tx_buffer_empty_flag)
    else $error("ready flag not cleared on buffer write");

  txbuf_taken_a: assert property (
    st_q.tx_full && fifo_in_ready && !wr |=> tx_buffer_empty_flag)
    else $error("ready flag not set after byte taken");

  tx_count_a: assert property (
    tx_valid && tx_ready && !frame_start
    |=> st_q.frame_left == $past(st_q.frame_left) - 8'h01)
    else $error("sent byte not counted");

  rx_capture_a: assert property (
    receive_start_flag
    |=> st_q.ma_hi == $past(rx_info.master_addr[11:4])
        && st_q.ma_lo == $past(rx_info.master_addr[3:0])
        && st_q.rx_ctl == $past(rx_info.ctrl))
    else $error("rx capture missed");

  bcast_err_a: assert property (
    ctrl_field_rx && st_q.bcast_sel && !rx_buf_enabled
    |=> rx_error && st_q.ma_hi == $past(rx_info.master_addr[11:4]))
    else $error("broadcast error not raised");

  ro_hold_a: assert property (
    !receive_start_flag && !bcast_err |=> $stable(st_q.ma_hi)
    && $stable(st_q.ma_lo) && $stable(st_q.rx_ctl))
    else $error("read-only capture changed");

  ack_single_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held two cycles");

  dsa_lo_write_a: assert property (
    wr && idx == `VBAR_IDX_DSA_LO
    |=> st_q.dsa_lo == $past(wb_req.dat[`VBAR_NIB_HI]))
    else $error("destination low nibble not stored");

  len_write_a: assert property (
    wr && idx == `VBAR_IDX_TX_LEN
    |=> st_q.tx_len == $past(wb_req.dat[`VBAR_BYTE]))
    else $error("length register not stored");

  txbuf_keep_a: assert property (
    st_q.tx_full && !fifo_in_ready |=> !tx_buffer_empty_flag)
    else $error("ready flag set while byte still held");

  tx_gate_a: assert property (
    st_q.frame_left == '0 |-> !tx_valid)
    else $error("byte offered outside a frame");

  tx_head_a: assert property (
    tx_valid && !tx_ready && !frame_start
    |=> tx_valid && $stable(tx_data))
    else $error("offered byte changed before taken");

  ma_lo_read_a: assert property (
    req && !st_q.ack && !wb_req.we && mapped && idx == `VBAR_IDX_MA_LO
    |=> wb_rsp.dat == {24'h0, $past(st_q.ma_lo), `VBAR_ZERO_NIB})
    else $error("master address low read wrong");

  ma_hi_read_a: assert property (
    req && !st_q.ack && !wb_req.we && mapped && idx == `VBAR_IDX_MA_HI
    |=> wb_rsp.dat == {24'h0, $past(st_q.ma_hi)})
    else $error("master address high read wrong");

  ctl_read_a: assert property (
    req && !st_q.ack && !wb_req.we && mapped && idx == `VBAR_IDX_RX_CTL
    |=> wb_rsp.dat == {28'h0, $past(st_q.rx_ctl)})
    else $error("control field read wrong");

  status_read_a: assert property (
    req && !st_q.ack && !wb_req.we && mapped && idx == `VBAR_IDX_STATUS
    |=> wb_rsp.dat[`VBAR_ST_TXE_BIT] == $past(tx_buffer_empty_flag))
    else $error("ready flag read wrong");

  bcast_ctl_keep_a: assert property (
    bcast_err && !receive_start_flag |=> $stable(st_q.rx_ctl))
    else $error("control field changed by broadcast error");

  rx_err_pulse_a: assert property (
    !bcast_err |=> !rx_error)
    else $error("receive error without cause");

  unmapped_read_a: assert property (
    req && !st_q.ack && !mapped |=> wb_rsp.dat == '0)
    else $error("unmapped read not zero");

  ack_idle_a: assert property (!wb_rsp.ack |-> wb_rsp.dat == '0)
    else $error("read data outside ack");
endmodule // vbar_regs
`default_nettype wire

/* File: rtl/vbar_consts.svh */
`ifndef VBAR_CONSTS_SVH
`define VBAR_CONSTS_SVH

// register word index, byte address is four times the index
`define VBAR_IDX_DSA_HI  3'h0
`define VBAR_IDX_DSA_LO  3'h1
`define VBAR_IDX_TX_LEN  3'h2
`define VBAR_IDX_TX_BUF  3'h3
`define VBAR_IDX_MA_LO   3'h4
`define VBAR_IDX_MA_HI   3'h5
`define VBAR_IDX_RX_CTL  3'h6
`define VBAR_IDX_STATUS  3'h7

// field positions
`define VBAR_NIB_HI      7:4
`define VBAR_NIB_LO      3:0
`define VBAR_ADDR_HI     11:4
`define VBAR_ADDR_LO     3:0
`define VBAR_BYTE        7:0
`define VBAR_ST_TXE_BIT  0
`define VBAR_ST_BSEL_BIT 1

// bus address fields
`define VBAR_ADR_IDX     4:2
`define VBAR_ADR_UPPER   31:5
`define VBAR_SEL_LANE0   0

// reset values and fillers
`define VBAR_RST_BYTE    8'h00
`define VBAR_RST_NIB     4'h0
`define VBAR_ZERO_NIB    4'h0
`define VBAR_ZERO_WORD   32'h0000_0000
`define VBAR_ONE_BYTE    8'h01

// tx fifo shape
`define VBAR_FIFO_WIDTH  8
`define VBAR_FIFO_DEPTH  32

`endif

/* File: rtl/vbar_pkg.sv */
package vbar_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } vbar_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } vbar_wb_rsp_t;

  typedef struct packed {
    logic [11:0] master_addr;
    logic [3:0]  ctrl;
  } vbar_rx_info_t;

  typedef struct packed {
    logic [7:0]  dsa_hi;
    logic [3:0]  dsa_lo;
    logic [7:0]  tx_len;
    logic [7:0]  tx_hold;
    logic        tx_full;
    logic        bcast_sel;
    logic [3:0]  ma_lo;
    logic [7:0]  ma_hi;
    logic [3:0]  rx_ctl;
    logic [7:0]  frame_left;
    logic [7:0]  frame_bytes;
    logic        frame_more;
    logic        rx_err;
    logic        ack;
    logic [31:0] rdata;
  } vbar_regs_st_t;

endpackage

/* File: bench/vbar_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// line side transmit engine model
// ----------------------------------------
module vbar_engine_model (
  input  wire logic       clk,      // system clock
  input  wire logic       reset,    // async, active high
  input  wire logic       tx_valid, // byte offered
  input  wire logic [7:0] tx_data,  // offered byte
  input  wire logic       stall,    // hold off taking bytes
  output logic            tx_ready, // byte taken
  output int              count     // bytes taken so far
);
  logic [7:0] seen [0:63];

  assign tx_ready = !stall;

  // bytes land in the frame data field in order
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= 0;
    end else if (tx_valid && tx_ready && count < 64) begin
      seen[count] <= tx_data;
      count       <= count + 1;
    end
  end
endmodule // vbar_engine_model
`default_nettype wire

/* File: bench/vbar_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module vbar_regs_tb;
  import vbar_pkg::*;
  logic            clk = 1'b0;
  logic            reset = 1'b1;
  vbar_wb_req_t    wb_req = '0;
  vbar_wb_rsp_t    wb_rsp;
  logic [11:0]     dest_addr;
  logic            tx_buffer_empty_flag;
  logic            frame_start = 1'b0;
  logic [7:0]      frame_max = 8'h00;
  logic [7:0]      frame_bytes;
  logic            frame_more;
  logic            tx_valid;
  logic            tx_ready;
  logic [7:0]      tx_data;
  logic            stall = 1'b1;
  logic            receive_start_flag = 1'b0;
  vbar_rx_info_t   rx_info = '0;
  logic            ctrl_field_rx = 1'b0;
  logic            rx_buf_enabled = 1'b1;
  logic            rx_error;
  int              count;
  int              fail_count = 0;
  int              compares = 0;

  always #2.5 clk = ~clk;

  vbar_regs dut (.clk(clk), .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .dest_addr(dest_addr), .tx_buffer_empty_flag(tx_buffer_empty_flag),
    .frame_start(frame_start), .frame_max(frame_max),
    .frame_bytes(frame_bytes), .frame_more(frame_more),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .receive_start_flag(receive_start_flag), .rx_info(rx_info),
    .ctrl_field_rx(ctrl_field_rx), .rx_buf_enabled(rx_buf_enabled),
    .rx_error(rx_error));

  vbar_engine_model eng (.clk(clk), .reset(reset), .tx_valid(tx_valid),
    .tx_data(tx_data), .stall(stall), .tx_ready(tx_ready), .count(count));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle, entered at a rising edge; ack judged at the edge
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int k;
    k = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1,
                dat: {24'h0, d}};
    do begin
      @(posedge clk);
      k++;
    end while (wb_rsp.ack !== 1'b1 && k < 20);
    if (k >= 20) chk(32'h0, 32'h1);
    q = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic pulse_start(input logic [7:0] mx);
    frame_max   <= mx;
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    @(posedge clk);
  endtask

  task automatic drain(input int n);
    int k;
    k = 0;
    stall <= 1'b0;
    while (count < n && k < 300) begin
      @(posedge clk);
      k++;
    end
    repeat (4) @(posedge clk);
    stall <= 1'b1;
    chk(32'(count), 32'(n));
  endtask

  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rd_chk(32'(4 * i), (i == 7) ? 32'h1 : 32'h0);
    end
    rd_chk(32'h0000_0020, 32'h0);
    $display("test reset values done");
  endtask

  // slave-only reception needs no destination setup
  task automatic t_rx();
    rx_info            <= '{master_addr: 12'h9b7, ctrl: 4'hd};
    receive_start_flag <= 1'b1;
    @(posedge clk);
    receive_start_flag <= 1'b0;
    rx_info            <= '{master_addr: 12'h5e2, ctrl: 4'h6};
    @(posedge clk);
    for (int p = 0; p < 2; p++) begin
      rd_chk(32'h10, 32'h70);
      rd_chk(32'h14, 32'h9b);
      rd_chk(32'h18, 32'h0d);
      wr(32'h10, 8'hff);
      wr(32'h14, 8'hff);
      wr(32'h18, 8'hff);
    end
    wr(32'h1c, 8'h02);
    rd_chk(32'h1c, 32'h3);
    rx_buf_enabled <= 1'b0;
    ctrl_field_rx  <= 1'b1;
    @(posedge clk);
    ctrl_field_rx  <= 1'b0;
    rx_buf_enabled <= 1'b1;
    #1;
    chk({31'h0, rx_error}, 32'h1);
    @(posedge clk);
    #1;
    chk({31'h0, rx_error}, 32'h0);
    @(posedge clk);
    rd_chk(32'h10, 32'h20);
    rd_chk(32'h14, 32'h5e);
    rd_chk(32'h18, 32'h0d);
    $display("test receive capture done");
  endtask

  task automatic t_dest();
    wr(32'h00, 8'ha5);
    wr(32'h04, 8'h3c);
    rd_chk(32'h00, 32'ha5);
    rd_chk(32'h04, 32'h30);
    chk({20'h0, dest_addr}, 32'ha53);
    wr(32'h0000_0020, 8'h11);
    rd_chk(32'h00, 32'ha5);
    $display("test destination done");
  endtask

  task automatic t_tx();
    int k;
    for (int i = 0; i < 33; i++) begin
      k = 0;
      while (tx_buffer_empty_flag !== 1'b1 && k < 50) begin
        @(posedge clk);
        k++;
      end
      wr(32'h0c, 8'h40 + 8'(i));
    end
    repeat (4) @(posedge clk);
    chk({31'h0, tx_buffer_empty_flag}, 32'h0);
    rd_chk(32'h0c, 32'h60);
    wr(32'h08, 8'h28);
    pulse_start(8'd20);
    chk({24'h0, frame_bytes}, 32'd20);
    chk({31'h0, frame_more}, 32'h1);
    drain(20);
    rd_chk(32'h08, 32'h28);
    wr(32'h08, 8'h0d);
    pulse_start(8'd20);
    chk({24'h0, frame_bytes}, 32'd13);
    chk({31'h0, frame_more}, 32'h0);
    drain(33);
    for (int i = 0; i < 33; i++) begin
      chk({24'h0, eng.seen[i]}, 32'h40 + 32'(i));
    end
    chk({31'h0, tx_buffer_empty_flag}, 32'h1);
    $display("test transmit path done");
  endtask

  task automatic final_report();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rx();
    t_dest();
    t_tx();
    final_report();
  end

  initial begin
    #100000;
    fail_count++;
    final_report();
  end
endmodule // vbar_regs_tb
`default_nettype wire
